// File: rtl/cse_pkg.sv
package cse_pkg;

    // Widths
    localparam int PC_W    = 12;
    localparam int SP_W    = 16;
    localparam int NUM_IRQ = 8;
    localparam int IO_AW   = 6;
    localparam int RF_AW   = 5;

    // I/O register addresses
    localparam logic [IO_AW-1:0] IO_IRQ_EN   = 6'h39;
    localparam logic [IO_AW-1:0] IO_IRQ_FLAG = 6'h3A;
    localparam logic [IO_AW-1:0] IO_GIC      = 6'h3B;
    localparam logic [IO_AW-1:0] IO_SP_LOW   = 6'h3D;
    localparam logic [IO_AW-1:0] IO_SP_HIGH  = 6'h3E;
    localparam logic [IO_AW-1:0] IO_STATUS   = 6'h3F;

    // Field positions
    localparam int STATUS_IBIT = 7;
    localparam int VSEL_BIT    = 1;

    // Reset values
    localparam logic [7:0]         STATUS_RST  = 8'h00;
    localparam logic [7:0]         GIC_RST     = 8'h00;
    localparam logic [7:0]         BYTE_RST    = 8'h00;
    localparam logic [NUM_IRQ-1:0] IRQ_RST     = 8'h00;
    localparam logic [SP_W-1:0]    SP_RST      = 16'h0000;

    // Sources served as level type; the rest latch a flag
    localparam logic [NUM_IRQ-1:0] LEVEL_TYPE_MASK = 8'h80;

    // Vector placement
    localparam logic [PC_W-1:0] APP_START      = 12'h000;
    localparam logic [PC_W-1:0] BOOT_START_DEF = 12'hC00;
    localparam logic [PC_W-1:0] VEC_STEP       = 12'h001;

    // Stack steps and the lowest legal stack address
    localparam logic [SP_W-1:0] SP_STEP_BYTE = 16'h0001;
    localparam logic [SP_W-1:0] SP_STEP_ADDR = 16'h0002;
    localparam logic [SP_W-1:0] STACK_FLOOR  = 16'h0060;

    // Pointer pairs in the register file (low byte index)
    localparam logic [RF_AW-1:0] PTR_X_LOW = 5'h1A;
    localparam logic [RF_AW-1:0] PTR_Y_LOW = 5'h1C;
    localparam logic [RF_AW-1:0] PTR_Z_LOW = 5'h1E;
    localparam logic [RF_AW-1:0] PTR_HIGH_OFS = 5'h01;

    typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_MOV} cse_alu_op_t;
    typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} cse_ptr_sel_t;
    typedef enum logic [1:0] {PTR_DISP, PTR_POSTINC, PTR_PREDEC} cse_ptr_mode_t;

endpackage

// File: rtl/cse_reg_file.sv
`timescale 1ns/100ps
`default_nettype none
module cse_reg_file
    import cse_pkg::*;
(
    input wire logic clk,
    input wire logic rstSync_n,
    cse_rf_if.file   rf
);

    logic [7:0]  regs [32];
    logic [7:0]  opA;
    logic [7:0]  opB;
    logic [15:0] ptrBase;
    logic [15:0] ptrNext;
    logic [4:0]  ptrLow;

    // Pointer pair decode, shared by read and write-back
    function automatic logic [4:0] pairLow(input cse_ptr_sel_t s);
        unique case (s)
            PTR_X:   pairLow = PTR_X_LOW;
            PTR_Y:   pairLow = PTR_Y_LOW;
            PTR_Z:   pairLow = PTR_Z_LOW;
            default: pairLow = PTR_Z_LOW;
        endcase
    endfunction

    function automatic logic [7:0] aluCalc(input cse_alu_op_t op, input logic [7:0] a, input logic [7:0] b);
        unique case (op)
            ALU_ADD: aluCalc = a + b;
            ALU_SUB: aluCalc = a - b;
            ALU_AND: aluCalc = a & b;
            ALU_OR:  aluCalc = a | b;
            ALU_XOR: aluCalc = a ^ b;
            ALU_MOV: aluCalc = b;
            default: aluCalc = b;
        endcase
    endfunction

    assign opA          = regs[rf.dstSel];
    assign opB          = rf.useImm ? rf.imm : regs[rf.srcSel];
    assign rf.aluResult = aluCalc(rf.aluOp, opA, opB);

    assign ptrLow  = pairLow(rf.ptrSel);
    assign ptrBase = {regs[ptrLow + PTR_HIGH_OFS], regs[ptrLow]};

    // Effective address and post-access pointer value
    always_comb begin
        rf.ptrAddr = ptrBase;
        ptrNext    = ptrBase;
        unique case (rf.ptrMode)
            PTR_DISP:    rf.ptrAddr = ptrBase + {10'h000, rf.ptrDisp};
            PTR_POSTINC: ptrNext    = ptrBase + SP_STEP_BYTE;
            PTR_PREDEC: begin
                rf.ptrAddr = ptrBase - SP_STEP_BYTE;
                ptrNext    = ptrBase - SP_STEP_BYTE;
            end
            default:     rf.ptrAddr = ptrBase;
        endcase
    end

    // result written back same edge; pointer update wins on overlap
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            for (int i = 0; i < 32; i++) begin
                regs[i] <= BYTE_RST;
            end
        end else begin
            if (rf.aluWe) begin
                regs[rf.dstSel] <= rf.aluResult;
            end
            if (rf.ptrGo && rf.ptrMode != PTR_DISP) begin
                regs[ptrLow]                <= ptrNext[7:0];
                regs[ptrLow + PTR_HIGH_OFS] <= ptrNext[15:8];
            end
        end
    end

endmodule // cse_reg_file
`default_nettype wire

// File: rtl/cse_rf_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cse_rf_if;
    import cse_pkg::*;
    logic          aluWe;
    cse_alu_op_t   aluOp;
    logic [4:0]    dstSel;
    logic [4:0]    srcSel;
    logic          useImm;
    logic [7:0]    imm;
    logic [7:0]    aluResult;
    logic          ptrGo;
    cse_ptr_sel_t  ptrSel;
    cse_ptr_mode_t ptrMode;
    logic [5:0]    ptrDisp;
    logic [15:0]   ptrAddr;

    modport core (output aluWe, aluOp, dstSel, srcSel, useImm, imm, ptrGo, ptrSel, ptrMode, ptrDisp,
                  input aluResult, ptrAddr);
    modport file (input aluWe, aluOp, dstSel, srcSel, useImm, imm, ptrGo, ptrSel, ptrMode, ptrDisp,
                  output aluResult, ptrAddr);
endinterface
`default_nettype wire

// File: rtl/cse_stack_int_unit.sv
// Function
// - byte push lowers stack pointer by one, byte pop raises it by one.
// - call or interrupt entry lowers it by two; returns raise it by two.
// - stack pointer is two I/O bytes, readable, writable, reset to zero.
// - top six registers act as three 16-bit pointers with auto modes.
// - logic runs on the undivided chip clock.
// - ALU reads two operands, computes and writes back in one cycle.
// - interrupt taken only with individual and global enables both set.
// - boot lock bits suppress interrupts depending on program counter.
// - vectors at lowest addresses; lower index means higher priority.
// - vector select bit moves interrupt vectors to boot section start.
// - boot reset fuse moves reset vector to boot section start.
// - entry clears global enable; software may set it to nest.
// - return from interrupt sets global enable.
// - latched flag cleared by hardware when its handler is vectored.
// - writing one to a flag position clears that flag.
// - events set flags while disabled; served later in priority order.
// - level sources request only while present; nothing latched.
// - after return one main instruction runs before any interrupt.
// - status register is neither saved on entry nor restored on return.
// - clear-enable instruction blocks interrupts at once, same cycle too.
// - after set-enable instruction, next instruction runs before interrupts.
// - entry takes four cycles pushing the return address before vector.
// - return takes four cycles, pops address, raises pointer, sets enable.
`timescale 1ns/100ps
`default_nettype none
module cse_stack_int_unit
    import cse_pkg::*;
#(
    parameter logic [PC_W-1:0] BOOT_START = BOOT_START_DEF
)
(
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               instrDone,
    input  wire logic [PC_W-1:0]    pcNext,
    input  wire logic [PC_W-1:0]    pcNow,
    input  wire logic               seiExec,
    input  wire logic               cliExec,
    input  wire logic               retiExec,
    input  wire logic               pushByte,
    input  wire logic               popByte,
    input  wire logic               callPush,
    input  wire logic               retPop,
    input  wire logic [IO_AW-1:0]   ioAddr,
    input  wire logic               ioWe,
    input  wire logic               ioRe,
    input  wire logic [7:0]         ioWrData,
    output logic      [7:0]         ioRdData,
    input  wire logic [NUM_IRQ-1:0] irqEvent,
    input  wire logic [NUM_IRQ-1:0] irqLevel,
    input  wire logic               bootResetFuse,
    input  wire logic               appLockBit,
    input  wire logic               bootLockBit,
    input  wire logic               aluWe,
    input  wire cse_alu_op_t        aluOp,
    input  wire logic [4:0]         dstSel,
    input  wire logic [4:0]         srcSel,
    input  wire logic               useImm,
    input  wire logic [7:0]         imm,
    output logic      [7:0]         aluResult,
    input  wire logic               ptrGo,
    input  wire cse_ptr_sel_t       ptrSel,
    input  wire cse_ptr_mode_t      ptrMode,
    input  wire logic [5:0]         ptrDisp,
    output logic      [15:0]        ptrAddr,
    output logic                    entryTaken,
    output logic                    busy,
    output logic                    memWe,
    output logic                    memRe,
    output logic      [SP_W-1:0]    memAddr,
    output logic      [7:0]         memWrData,
    input  wire logic [7:0]         memRdData,
    output logic                    vectorLoad,
    output logic      [PC_W-1:0]    vectorAddr,
    output logic                    pcLoad,
    output logic      [PC_W-1:0]    retPc,
    output logic      [PC_W-1:0]    resetVector,
    output logic      [7:0]         statusReg,
    output logic      [SP_W-1:0]    stackPtr
);

    typedef enum {ST_RUN, ST_ENT1, ST_ENT2, ST_ENT3, ST_ENT4, ST_RET1, ST_RET2, ST_RET3, ST_RET4} cse_state_t;

    cse_state_t         state;
    logic [1:0]         rstPipe;
    logic               rstSync_n;
    logic [2:0]         strapMeta;
    logic [2:0]         strapSync;
    logic [7:0]         gicReg;
    logic [NUM_IRQ-1:0] irqEnable;
    logic [NUM_IRQ-1:0] irqFlag;
    logic [NUM_IRQ-1:0] irqReq;
    logic [NUM_IRQ-1:0] vecClear;
    logic [2:0]         pickIdx;
    logic [2:0]         vecIdx;
    logic               anyReq;
    logic               gieNow;
    logic               holdoff;
    logic               lockBlock;
    logic               takeIrq;
    logic [PC_W-1:0]    savedPc;
    logic [PC_W-1:0]    vecBase;
    logic [7:0]         popHigh;

    cse_rf_if rfBus ();

    function automatic logic ioHit(input logic [IO_AW-1:0] a, input logic [IO_AW-1:0] reg_a);
        ioHit = (a == reg_a);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset release and strap synchronisers
    // single undivided clock for everything
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe[1];

    // Fuse and lock levels come from off-domain pins
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            strapMeta <= 3'b000;
            strapSync <= 3'b000;
        end else begin
            strapMeta <= {bootLockBit, appLockBit, bootResetFuse};
            strapSync <= strapMeta;
        end
    end

    assign resetVector = strapSync[0] ? BOOT_START : APP_START;

    ////////////////////////////////////////////////////////////////////////
    // Register file and stack pointer
    assign rfBus.aluWe   = aluWe;
    assign rfBus.aluOp   = aluOp;
    assign rfBus.dstSel  = dstSel;
    assign rfBus.srcSel  = srcSel;
    assign rfBus.useImm  = useImm;
    assign rfBus.imm     = imm;
    assign rfBus.ptrGo   = ptrGo;
    assign rfBus.ptrSel  = ptrSel;
    assign rfBus.ptrMode = ptrMode;
    assign rfBus.ptrDisp = ptrDisp;
    assign aluResult     = rfBus.aluResult;
    assign ptrAddr       = rfBus.ptrAddr;

    cse_reg_file uRegFile (
        .clk       (core_clk),
        .rstSync_n (rstSync_n),
        .rf        (rfBus.file)
    );

    // the floor is software's to respect; pointer is not clamped
    // entry pushes and return pops are folded into two-byte steps
    cse_stack_ptr uStack (
        .clk       (core_clk),
        .rstSync_n (rstSync_n),
        .wrLow     (ioWe && ioHit(ioAddr, IO_SP_LOW)),
        .wrHigh    (ioWe && ioHit(ioAddr, IO_SP_HIGH)),
        .wrData    (ioWrData),
        .dec1      (pushByte),
        .dec2      (callPush || state == ST_ENT2),
        .inc1      (popByte),
        .inc2      (retPop || state == ST_RET3),
        .sp        (stackPtr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request selection
    // level sources pass straight through, never latched
    assign irqReq = (irqFlag | (irqLevel & LEVEL_TYPE_MASK)) & irqEnable;
    assign anyReq = |irqReq;

    always_comb begin
        pickIdx = 3'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (irqReq[i]) begin
                pickIdx = 3'(i);
            end
        end
    end

    assign gieNow = statusReg[STATUS_IBIT] && !cliExec;

    // block when vectors sit in a section locked against the running code
    assign vecBase   = gicReg[VSEL_BIT] ? BOOT_START : APP_START;
    assign lockBlock = (strapSync[1] && gicReg[VSEL_BIT] && pcNow < BOOT_START) ||
                       (strapSync[2] && !gicReg[VSEL_BIT] && pcNow >= BOOT_START);

    // global enable gate; holdoff after return or set-enable
    assign takeIrq    = state == ST_RUN && instrDone && !holdoff && !seiExec && !retiExec &&
                        gieNow && anyReq && !lockBlock;
    assign entryTaken = takeIrq;
    assign busy       = state != ST_RUN;

    ////////////////////////////////////////////////////////////////////////
    // Flags and enables
    // hardware clear at vectoring
    assign vecClear = takeIrq ? (NUM_IRQ'(1) << pickIdx) & ~LEVEL_TYPE_MASK : IRQ_RST;

    // events latch regardless of enables; write one clears; set wins
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            irqFlag <= IRQ_RST;
        end else begin
            irqFlag <= (irqFlag & ~vecClear & ~((ioWe && ioHit(ioAddr, IO_IRQ_FLAG)) ? ioWrData : IRQ_RST))
                       | (irqEvent & ~LEVEL_TYPE_MASK);
        end
    end

    // vector select lives in the general control register
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            irqEnable <= IRQ_RST;
            gicReg    <= GIC_RST;
        end else begin
            if (ioWe && ioHit(ioAddr, IO_IRQ_EN)) begin
                irqEnable <= ioWrData;
            end
            if (ioWe && ioHit(ioAddr, IO_GIC)) begin
                gicReg <= ioWrData;
            end
        end
    end

    // only the enable bit is touched by hardware; nothing saved
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            statusReg <= STATUS_RST;
        end else begin
            if (ioWe && ioHit(ioAddr, IO_STATUS)) begin
                statusReg <= ioWrData;
            end
            if (seiExec) begin
                statusReg[STATUS_IBIT] <= 1'b1;
            end
            if (cliExec) begin
                statusReg[STATUS_IBIT] <= 1'b0;
            end
            if (takeIrq) begin
                statusReg[STATUS_IBIT] <= 1'b0;
            end
            if (state == ST_RET3) begin
                statusReg[STATUS_IBIT] <= 1'b1;
            end
        end
    end

    // one instruction must complete after set-enable or a return
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            holdoff <= 1'b0;
        end else if (seiExec || state == ST_RET4) begin
            holdoff <= 1'b1;
        end else if (instrDone && !retiExec) begin
            holdoff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry and return sequencer
    // four entry cycles; four return cycles
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= ST_RUN;
        end else begin
            unique case (state)
                ST_RUN:  state <= takeIrq ? ST_ENT1 : (retiExec ? ST_RET1 : ST_RUN);
                ST_ENT1: state <= ST_ENT2;
                ST_ENT2: state <= ST_ENT3;
                ST_ENT3: state <= ST_ENT4;
                ST_ENT4: state <= ST_RUN;
                ST_RET1: state <= ST_RET2;
                ST_RET2: state <= ST_RET3;
                ST_RET3: state <= ST_RET4;
                ST_RET4: state <= ST_RUN;
            endcase
        end
    end

    // capture the address that would have run next
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            savedPc <= APP_START;
            vecIdx  <= 3'h0;
        end else if (takeIrq) begin
            savedPc <= pcNext;
            vecIdx  <= pickIdx;
        end
    end

    // low byte then high byte pushed; high then low popped
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            memWe      <= 1'b0;
            memRe      <= 1'b0;
            memAddr    <= SP_RST;
            memWrData  <= BYTE_RST;
            vectorLoad <= 1'b0;
            vectorAddr <= APP_START;
            pcLoad     <= 1'b0;
            retPc      <= APP_START;
            popHigh    <= BYTE_RST;
        end else begin
            memWe      <= 1'b0;
            memRe      <= 1'b0;
            vectorLoad <= 1'b0;
            pcLoad     <= 1'b0;
            if (takeIrq) begin
                memWe     <= 1'b1;
                memAddr   <= stackPtr;
                memWrData <= pcNext[7:0];
            end else if (state == ST_RUN && retiExec) begin
                memRe   <= 1'b1;
                memAddr <= stackPtr + SP_STEP_BYTE;
            end
            if (state == ST_ENT1) begin
                memWe     <= 1'b1;
                memAddr   <= stackPtr - SP_STEP_BYTE;
                memWrData <= 8'(savedPc >> 8);
            end
            // Vector number counts from one; slot zero is reset
            if (state == ST_ENT3) begin
                vectorLoad <= 1'b1;
                vectorAddr <= vecBase + VEC_STEP * PC_W'(vecIdx) + VEC_STEP;
            end
            if (state == ST_RET1) begin
                memRe   <= 1'b1;
                memAddr <= stackPtr + SP_STEP_ADDR;
            end
            if (state == ST_RET2) begin
                popHigh <= memRdData;
            end
            if (state == ST_RET3) begin
                pcLoad <= 1'b1;
                retPc  <= PC_W'({popHigh, memRdData});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // I/O read port, one cycle latency; unmapped reads zero
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ioRdData <= BYTE_RST;
        end else if (ioRe) begin
            ioRdData <= BYTE_RST;
            if (ioHit(ioAddr, IO_SP_LOW))   ioRdData <= stackPtr[7:0];
            if (ioHit(ioAddr, IO_SP_HIGH))  ioRdData <= stackPtr[15:8];
            if (ioHit(ioAddr, IO_STATUS))   ioRdData <= statusReg;
            if (ioHit(ioAddr, IO_GIC))      ioRdData <= gicReg;
            if (ioHit(ioAddr, IO_IRQ_EN))   ioRdData <= irqEnable;
            if (ioHit(ioAddr, IO_IRQ_FLAG)) ioRdData <= irqFlag;
        end
    end

endmodule // cse_stack_int_unit
`default_nettype wire

// File: rtl/cse_stack_ptr.sv
`timescale 1ns/100ps
`default_nettype none
module cse_stack_ptr
    import cse_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rstSync_n,
    input  wire logic            wrLow,
    input  wire logic            wrHigh,
    input  wire logic [7:0]      wrData,
    input  wire logic            dec1,
    input  wire logic            dec2,
    input  wire logic            inc1,
    input  wire logic            inc2,
    output logic      [SP_W-1:0] sp
);

    // two bytes, reset zero; software write beats stack steps
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            sp <= SP_RST;
        end else if (wrLow) begin
            sp[7:0] <= wrData;
        end else if (wrHigh) begin
            sp[15:8] <= wrData;
        end else if (dec1) begin
            sp <= sp - SP_STEP_BYTE;
        end else if (inc1) begin
            sp <= sp + SP_STEP_BYTE;
        end else if (dec2) begin
            sp <= sp - SP_STEP_ADDR;
        end else if (inc2) begin
            sp <= sp + SP_STEP_ADDR;
        end
    end

endmodule // cse_stack_ptr
`default_nettype wire

// File: tb/cse_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module cse_mem_model
    import cse_pkg::*;
(
    input  wire logic            clk, memWe, memRe,
    input  wire logic [SP_W-1:0] memAddr,
    input  wire logic [7:0]      memWrData,
    output logic      [7:0]      memRdData = 8'h00
);
    logic [7:0] mem [256];
    // Data answers one cycle after a read; otherwise the bus toggles
    always @(posedge clk) begin
        if (memWe)
            mem[memAddr[7:0]] <= memWrData;
        memRdData <= memRe ? mem[memAddr[7:0]] : ~memRdData;
    end
endmodule // cse_mem_model
`default_nettype wire

// File: tb/cse_stack_int_sva.sv
`timescale 1ns/100ps
`default_nettype none
module cse_stack_int_sva
    import cse_pkg::*;
(
    input wire logic            core_clk, rst_n, pushByte, popByte, callPush, retPop, ioWe, busy,
    input wire logic            entryTaken, cliExec, retiExec, memWe, memRe, vectorLoad, pcLoad,
    input wire logic [7:0]      statusReg, memWrData,
    input wire logic [SP_W-1:0] stackPtr, memAddr,
    input wire logic [PC_W-1:0] pcNext
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Steps only judged when no software write or sequencer competes
    logic q;
    assign q = !ioWe && !busy;
    // Entry stores two bytes, top of stack downward
    sequence sPushPair;
        memWe && memAddr == $past(stackPtr) ##1 memWe && memAddr == $past(stackPtr, 2) - SP_STEP_BYTE;
    endsequence
    sequence sPopPair;
        memRe ##1 memRe;
    endsequence
    AST_PUSH: assert property (pushByte && q |=> stackPtr == $past(stackPtr) - SP_STEP_BYTE)
        else $error("push step wrong");
    AST_POP: assert property (popByte && q |=> stackPtr == $past(stackPtr) + SP_STEP_BYTE)
        else $error("pop step wrong");
    AST_CALL: assert property (callPush && q |=> stackPtr == $past(stackPtr) - SP_STEP_ADDR)
        else $error("call step wrong");
    AST_RET: assert property (retPop && q |=> stackPtr == $past(stackPtr) + SP_STEP_ADDR)
        else $error("return step wrong");
    AST_ENTRY: assert property (entryTaken |=> sPushPair ##2 vectorLoad)
        else $error("entry walk wrong");
    AST_RETADDR: assert property (entryTaken |=> {4'h0, memWrData} == ($past(pcNext) & 12'h0FF))
        else $error("pushed low byte wrong");
    AST_GLOBAL: assert property (entryTaken |-> statusReg[STATUS_IBIT])
        else $error("entry without global enable");
    AST_ICLR: assert property (entryTaken |=> !statusReg[STATUS_IBIT])
        else $error("global enable kept on entry");
    AST_CLI: assert property (cliExec |-> !entryTaken)
        else $error("entry beside clear");
    AST_RETURN_FROM_INTERRUPT: assert property (retiExec && !busy |=> sPopPair ##2 (pcLoad && statusReg[STATUS_IBIT]))
        else $error("return walk wrong");
endmodule // cse_stack_int_sva
bind cse_stack_int_unit cse_stack_int_sva u_cse_stack_int_sva (.*);
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import cse_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0;
    logic instrDone, seiExec, cliExec, retiExec, pushByte, popByte, callPush, retPop, ioWe, ioRe;
    logic bootResetFuse, appLockBit, bootLockBit, aluWe, useImm, ptrGo;
    logic entryTaken, busy, memWe, memRe, vectorLoad, pcLoad;
    logic [PC_W-1:0] pcNext, pcNow, vectorAddr, retPc, resetVector;
    logic [5:0] ioAddr, ptrDisp;
    logic [4:0] dstSel, srcSel;
    logic [7:0] ioWrData, ioRdData, imm, aluResult, memWrData, memRdData, statusReg, irqEvent, irqLevel;
    logic [15:0] memAddr, stackPtr, ptrAddr;
    cse_alu_op_t aluOp = ALU_MOV;
    cse_ptr_sel_t ptrSel = PTR_X;
    cse_ptr_mode_t ptrMode = PTR_PREDEC;
    int fails = 0, num_checks = 0;
    // Rows: push, pop, call, ret strobes, then stack pointer after
    logic [19:0] rows [6] = '{20'h8007F, 20'h8007E, 20'h4007F, 20'h2007D, 20'h1007F, 20'h40080};
    cse_stack_int_unit u_cse_stack_int_unit (.*);
    cse_mem_model u_cse_mem_model (.clk(core_clk), .*);
    always #20 core_clk = ~core_clk;
    task automatic tick(int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic io(logic we, logic [5:0] a, logic [7:0] d);
        {ioAddr, ioWe, ioRe, ioWrData} = {a, we, !we, d};
        tick();
        {ioWe, ioRe} = 2'b00;
        tick();
    endtask
    // Instruction boundary; entry is combinational
    task automatic boundary(logic take, logic [1:0] ex);
        {instrDone, seiExec, cliExec} = {1'b1, ex};
        #1 chk("entryTaken", take, entryTaken);
        tick();
        {instrDone, seiExec, cliExec} = 3'b000;
        tick();
    endtask
    task automatic waitHigh(ref logic s);
        for (int i = 0; i < 8 && s !== 1'b1; i++)
            tick();
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog: tests need under a hundred cycles
    initial begin
        #40000;
        fails++;
        conclude();
    end
    initial begin
        {instrDone, seiExec, cliExec, retiExec, pushByte, popByte, callPush, retPop, ioWe, ioRe} = '0;
        {bootResetFuse, appLockBit, bootLockBit, aluWe, useImm, ptrGo, pcNow, ptrDisp, srcSel} = '0;
        {pcNext, ioAddr, dstSel, ioWrData, imm, irqEvent, irqLevel} = '0;
        repeat (20) @(posedge core_clk);
        #1 rst_n = 1'b1;
        tick(3);
        io(0, IO_SP_HIGH, 0);
        chk("spHigh", 0, ioRdData);
        io(1, IO_SP_LOW, 8'h80);
        io(0, IO_SP_LOW, 0);
        chk("spLow", 16'h0080, ioRdData);
        for (int i = 0; i < 6; i++) begin
            {pushByte, popByte, callPush, retPop} = rows[i][19:16];
            tick();
            {pushByte, popByte, callPush, retPop} = 4'h0;
            chk("stackPtr", rows[i][15:0], stackPtr);
            tick();
        end
        {dstSel, useImm, imm, aluWe} = {PTR_X_LOW, 1'b1, 8'h10, 1'b1};
        #1 chk("aluResult", 8'h10, aluResult);
        tick();
        {dstSel, imm} = {PTR_X_LOW + PTR_HIGH_OFS, 8'h02};
        tick();
        {aluWe, ptrGo} = 2'b01;
        #1 chk("ptrAddr", 16'h020F, ptrAddr);
        tick();
        ptrGo = 1'b0;
        ptrMode = PTR_POSTINC;
        #1 chk("ptrAddr", 16'h020F, ptrAddr);
        io(1, IO_IRQ_EN, 8'h03);
        {irqEvent, irqLevel} = 16'h0780;
        tick();
        {irqEvent, irqLevel} = '0;
        io(0, IO_IRQ_FLAG, 0);
        chk("flags", 8'h07, ioRdData);
        io(1, IO_IRQ_FLAG, 8'h04);
        io(1, IO_STATUS, 8'h80);
        pcNext = 12'h123;
        boundary(1'b1, 2'b00);
        waitHigh(vectorLoad);
        chk("vectorAddr", 12'h001, vectorAddr);
        chk("busy", 1, busy);
        chk("pushLow", 8'h23, u_cse_mem_model.mem[8'h80]);
        chk("pushHigh", 8'h01, u_cse_mem_model.mem[8'h7F]);
        chk("stackPtr", 16'h007E, stackPtr);
        chk("status", 8'h00, statusReg);
        io(0, IO_IRQ_FLAG, 0);
        chk("flags", 8'h02, ioRdData);
        retiExec = 1'b1;
        tick();
        retiExec = 1'b0;
        waitHigh(pcLoad);
        chk("retPc", 12'h123, retPc);
        chk("stackPtr", 16'h0080, stackPtr);
        chk("status", 8'h80, statusReg);
        tick();
        boundary(1'b0, 2'b00);
        boundary(1'b0, 2'b01);
        appLockBit = 1'b1;
        io(1, IO_GIC, 8'h02);
        boundary(1'b0, 2'b10);
        boundary(1'b0, 2'b00);
        boundary(1'b0, 2'b00);
        appLockBit = 1'b0;
        tick(2);
        boundary(1'b1, 2'b00);
        waitHigh(vectorLoad);
        chk("vectorAddr", 12'hC02, vectorAddr);
        bootResetFuse = 1'b1;
        tick(4);
        chk("resetVector", 12'hC00, resetVector);
        conclude();
    end
endmodule // testbench
`default_nettype wire
